// file: rtl/swep_top.sv
// Single-wire return-to-one slave port with paged word array access.
// Assumes the line input is already synchronous to clk and pulled up outside.
// Functional notes
// - Line idles high, bits return high
// - Only pull low or release line
// - One data byte in or out
// - Command bit 7 picks direction
// - Map bit picks register or memory
// - Memory command: row and column fields
// - Register command: address 0x00 to 0x3F
// - Array is 128 words of 32 bits
// - Eight pages of sixteen word rows
// - Last four words of page 7 reserved
// - Page index picks 64-byte page
// - Column 3 is buffer high byte
// - Addressed word prefetched into buffer
// - Circuits enabled per power mode
// - Core reset held 4 ms
// - Ignore lows shorter than 1.98 us
// - Read answer starts 222 us later
// - Converter sampled at 65.5 kHz
`timescale 1ns/1ps
module swep_top
  import swep_pkg::*;
#(
  parameter int THR_C   = THR_CYC,
  parameter int BREAK_C = BREAK_CYC,
  parameter int DW0_C   = DW0_CYC,
  parameter int DCYC_C  = DCYC_CYC,
  parameter int RSP_C   = RSP_CYC,
  parameter int CRST_C  = CRST_CYC,
  parameter int CONV0_C = CONV0_CYC,
  parameter int CONV1_C = CONV1_CYC,
  parameter int CONV2_C = CONV2_CYC,
  parameter int CONV3_C = CONV3_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 line_in,
  output logic                      line_out,
  output logic                      line_oe,
  input  wire logic                 sleep_req,
  input  wire logic                 shutdown_req,
  input  wire logic                 conv_start,
  input  wire logic [1:0]           conv_speed,
  input  wire logic                 err_clear,
  output logic                      core_reset,
  output logic                      en_regulator,
  output logic                      en_slow_oscillator,
  output logic                      en_fast_oscillator,
  output logic                      en_port,
  output logic                      en_adc,
  output logic                      en_mem_read,
  output logic                      en_mem_write,
  output logic                      adc_sample,
  output logic                      conv_busy,
  output logic                      adc_ready,
  output logic                      prot_err,
  output logic [swep_pkg::PAGE_W-1:0] page
);
  import swep_pkg::*;

  // ****************************************************************
  // Array
  // ****************************************************************
  swep_mem_if mif ();
  swep_mem u_mem (.clk(clk), .rst(rst), .mif(mif));

  // ****************************************************************
  // Core reset stretch after power-on release
  // ****************************************************************
  logic [17:0] crst_cnt, next_crst_cnt;
  always_comb begin
    next_crst_cnt = crst_cnt;
    if (core_reset) next_crst_cnt = crst_cnt + 18'h00001;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) crst_cnt <= '0;
    else     crst_cnt <= next_crst_cnt;
  end
  assign core_reset = (crst_cnt < 18'(CRST_C));

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  swep_state_e       state, next_state;
  logic [15:0]       low_cnt, next_low_cnt;
  logic [15:0]       tcnt, next_tcnt;       // Response wait and bit time
  logic [2:0]        bit_cnt, next_bit_cnt;
  logic [7:0]        shreg, next_shreg;
  logic [7:0]        cmd, next_cmd;
  logic              have_cmd, next_have_cmd;
  logic [WORD_W-1:0] buffer, next_buffer;
  logic [PAGE_W-1:0] next_page;
  logic              drive, next_drive;
  logic              asleep, next_asleep, shut, next_shut, wake_ign, next_wake_ign;
  logic              prot, next_prot;
  logic              rise, bit_ok, byte_done, is_brk;
  logic [7:0]        rx_byte, rd_byte;
  logic [COL_W-1:0]  col;
  logic [ROW_W-1:0]  row;
  logic              trim_hit;

  assign col      = cmd[COL_W-1:0];
  assign row      = cmd[CMD_ROW_LSB +: ROW_W];
  assign mif.addr = {page, row};
  assign trim_hit = (page == TRIM_PAGE) && (row >= TRIM_ROW_MIN);
  // Lows are only timed on the rising edge, so glitches never shift
  assign rise     = line_in && (low_cnt != 16'h0000);
  assign is_brk   = low_cnt >= 16'(BREAK_C);
  assign bit_ok   = rise && !is_brk && (low_cnt >= 16'(FILT_CYC));
  assign rx_byte  = {(low_cnt < 16'(THR_C)), shreg[7:1]};
  assign byte_done = bit_ok && (bit_cnt == 3'h7);

  // Read data select, register space byte or buffer column
  always_comb begin
    rd_byte = 8'h00;
    if (cmd[CMD_MAP_BIT]) begin
      rd_byte = buffer[8*col +: 8];
    end else if (cmd[REG_W-1:0] <= RA_BUF3) begin
      rd_byte = buffer[8*cmd[1:0] +: 8];
    end else if (cmd[REG_W-1:0] == RA_STATUS) begin
      rd_byte = {conv_busy | (state == S_PROG), adc_ready, prot, 5'h00};
    end else if (cmd[REG_W-1:0] == RA_PAGE) begin
      rd_byte = {5'h00, page};
    end
  end

  // Next state of the port engine
  always_comb begin
    next_state    = state;
    next_low_cnt  = low_cnt;
    next_tcnt     = tcnt;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_cmd      = cmd;
    next_have_cmd = have_cmd;
    next_buffer   = buffer;
    next_page     = page;
    next_drive    = 1'b0;
    next_asleep   = asleep | (sleep_req & (state == S_RX) & ~have_cmd);
    next_shut     = shut | (shutdown_req & (state == S_RX) & ~have_cmd);
    next_wake_ign = wake_ign & ~line_in;
    next_prot     = prot & ~err_clear;
    mif.rd_en     = 1'b0;
    mif.wr_en     = 1'b0;
    mif.wdata     = buffer;
    // Wake pulse only restarts clocks; it never carries a bit
    if ((asleep || shut) && !line_in) begin
      next_asleep   = 1'b0;
      next_shut     = 1'b0;
      next_wake_ign = 1'b1;
    end
    if ((state != S_TX) && (state != S_WAIT)) begin
      next_tcnt = tcnt + 16'h0001;
    end
    case (state)
      S_RX: begin
        if (!line_in && !asleep && !shut && !wake_ign) begin
          if (low_cnt != 16'hFFFF) next_low_cnt = low_cnt + 16'h0001;
        end else if (line_in) begin
          next_low_cnt = 16'h0000;
        end
        if (rise && is_brk) begin
          next_bit_cnt  = 3'h0;                                         // Break restarts frame
          next_have_cmd = 1'b0;
        end else if (bit_ok) begin
          next_shreg   = rx_byte;
          next_bit_cnt = bit_cnt + 3'h1;
        end
        if (byte_done && !have_cmd) begin
          next_cmd      = rx_byte;
          next_have_cmd = 1'b1;
          next_tcnt     = 16'h0001;
          if (rx_byte[CMD_MAP_BIT]) next_state = S_FETCH;
          else if (!rx_byte[CMD_DIR_BIT]) next_state = S_WAIT;
        end else if (byte_done) begin
          next_have_cmd = 1'b0;
          if (cmd[CMD_MAP_BIT]) begin
            next_buffer[8*col +: 8] = rx_byte;
            next_state = S_PROG;
          end else if (cmd[REG_W-1:0] <= RA_BUF3) begin
            next_buffer[8*cmd[1:0] +: 8] = rx_byte;
          end else if (cmd[REG_W-1:0] == RA_PAGE) begin
            next_page = rx_byte[PAGE_W-1:0];
          end
        end
      end
      S_FETCH: begin
        mif.rd_en  = 1'b1;
        next_state = S_LOAD;
      end
      S_LOAD: begin
        next_buffer = mif.rdata;
        next_state  = cmd[CMD_DIR_BIT] ? S_RX : S_WAIT;
      end
      S_WAIT: begin
        next_tcnt = tcnt + 16'h0001;
        if (tcnt >= 16'(RSP_C)) begin
          next_state   = S_TX;
          next_shreg   = rd_byte;
          next_bit_cnt = 3'h0;
          next_tcnt    = 16'h0000;
          next_drive   = 1'b1;
        end
      end
      S_TX: begin
        next_tcnt  = tcnt + 16'h0001;
        // Low for the bit time, then released for the rest
        next_drive = (tcnt + 16'h0001) < (shreg[0] ? 16'(DW1_CYC) : 16'(DW0_C));
        if (tcnt == 16'(DCYC_C - 1)) begin
          next_tcnt    = 16'h0000;
          next_shreg   = {1'b0, shreg[7:1]};
          next_bit_cnt = bit_cnt + 3'h1;
          next_drive   = 1'b1;
          if (bit_cnt == 3'h7) begin
            next_state    = S_RX;
            next_have_cmd = 1'b0;
            next_drive    = 1'b0;
          end
        end
      end
      S_PROG: begin
        // Reserved trim words refuse user writes and raise the flag
        if (trim_hit) next_prot = 1'b1;
        else mif.wr_en = 1'b1;
        next_state = S_RX;
      end
      default: next_state = S_RX;
    endcase
    if (state != S_RX) next_low_cnt = 16'h0000;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_RX; low_cnt <= '0; tcnt <= '0; bit_cnt <= '0;
      shreg <= '0; cmd <= '0; have_cmd <= 1'b0; buffer <= '0;
      page <= '0; drive <= 1'b0; asleep <= 1'b0; shut <= 1'b0;
      wake_ign <= 1'b0; prot <= 1'b0;
    end else if (core_reset) begin
      state <= S_RX; low_cnt <= '0; tcnt <= '0; bit_cnt <= '0;
      shreg <= '0; cmd <= '0; have_cmd <= 1'b0; buffer <= '0;
      page <= '0; drive <= 1'b0; asleep <= 1'b0; shut <= 1'b0;
      wake_ign <= 1'b0; prot <= 1'b0;
    end else begin
      state <= next_state; low_cnt <= next_low_cnt; tcnt <= next_tcnt;
      bit_cnt <= next_bit_cnt; shreg <= next_shreg; cmd <= next_cmd;
      have_cmd <= next_have_cmd; buffer <= next_buffer; page <= next_page;
      drive <= next_drive; asleep <= next_asleep; shut <= next_shut;
      wake_ign <= next_wake_ign; prot <= next_prot;
    end
  end

  assign line_out = 1'b0;
  assign line_oe  = drive;
  assign prot_err = prot;

  // ****************************************************************
  // Temperature converter timing
  // ****************************************************************
  logic [23:0] conv_cnt, next_conv_cnt, conv_len;
  logic [9:0]  smp_cnt, next_smp_cnt;
  logic        next_busy, next_ready, next_sample;

  always_comb begin
    case (conv_speed)
      2'b00:   conv_len = 24'(CONV0_C);
      2'b01:   conv_len = 24'(CONV1_C);
      2'b10:   conv_len = 24'(CONV2_C);
      default: conv_len = 24'(CONV3_C);
    endcase
    next_busy     = conv_busy;
    next_ready    = adc_ready;
    next_conv_cnt = conv_cnt;
    next_smp_cnt  = smp_cnt;
    next_sample   = 1'b0;
    if (!conv_busy && conv_start) begin
      next_busy     = 1'b1;
      next_ready    = 1'b0;
      next_conv_cnt = 24'h000000;
      next_smp_cnt  = 10'h000;
    end else if (conv_busy) begin
      next_conv_cnt = conv_cnt + 24'h000001;
      next_smp_cnt  = smp_cnt + 10'h001;
      if (smp_cnt == 10'(SMP_CYC - 1)) begin
        next_smp_cnt = 10'h000;
        next_sample  = 1'b1;
      end
      if (conv_cnt == conv_len - 24'h000001) begin
        next_busy  = 1'b0;
        next_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_busy <= 1'b0; adc_ready <= 1'b0; conv_cnt <= '0;
      smp_cnt <= '0; adc_sample <= 1'b0;
    end else begin
      conv_busy <= next_busy & ~core_reset; adc_ready <= next_ready & ~core_reset;
      conv_cnt <= next_conv_cnt; smp_cnt <= next_smp_cnt;
      adc_sample <= next_sample & ~core_reset;
    end
  end

  // ****************************************************************
  // Power mode gating
  // ****************************************************************
  assign en_regulator       = !shut;
  assign en_slow_oscillator = !shut;
  assign en_fast_oscillator = !shut && !asleep;
  assign en_port            = en_fast_oscillator && (!line_in || state != S_RX || have_cmd
                              || conv_busy);
  assign en_adc             = conv_busy;
  assign en_mem_read        = (state == S_FETCH) || (state == S_LOAD);
  assign en_mem_write       = (state == S_PROG) && !trim_hit;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [23:0] h_conv;
  logic [15:0] h_oe;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_conv <= '0; h_oe <= '0;
    end else begin
      h_conv <= conv_busy ? h_conv + 24'h000001 : 24'h000000;
      h_oe   <= line_oe ? h_oe + 16'h0001 : 16'h0000;
    end
  end

  sequence s_fetch; state == S_FETCH; endsequence
  sequence s_load;  state == S_LOAD;  endsequence

  a_oe_only_tx: assert property (@(posedge clk) disable iff (rst)
    line_oe |-> (state == S_TX || $past(state) == S_TX)) else $error("line driven outside tx");
  a_tx_low_len: assert property (@(posedge clk) disable iff (rst)
    $fell(line_oe) |-> (h_oe == 16'(DW1_CYC) || h_oe == 16'(DW0_C)))
    else $error("bad low time");
  a_rsp_delay: assert property (@(posedge clk) disable iff (rst)
    (state == S_WAIT && $past(state) == S_RX) |-> (tcnt == 16'h0001))
    else $error("wait did not start at command end");
  a_prefetch_seq: assert property (@(posedge clk) disable iff (rst)
    s_fetch |=> s_load ##1 (buffer === $past(mif.rdata))) else $error("prefetch lost");
  a_short_pulse: assert property (@(posedge clk) disable iff (rst)
    (state == S_RX && rise && low_cnt < 16'(FILT_CYC)) |=> $stable(bit_cnt))
    else $error("glitch counted as bit");
  a_trim_guard: assert property (@(posedge clk) disable iff (rst)
    mif.wr_en |-> !trim_hit) else $error("trim word written");
  a_core_rst_len: assert property (@(posedge clk) disable iff (rst)
    $fell(core_reset) |-> crst_cnt == 18'(CRST_C)) else $error("core reset length");
  a_power_gate: assert property (@(posedge clk) disable iff (rst)
    (en_adc || en_mem_read || en_mem_write) |-> (en_slow_oscillator && en_regulator))
    else $error("circuit on without supply");
  a_conv_len: assert property (@(posedge clk) disable iff (rst || core_reset)
    $fell(conv_busy) && $past(adc_ready, 1) == 1'b0 && adc_ready |-> h_conv == $past(conv_len))
    else $error("conversion length");
  a_dir_decode: assert property (@(posedge clk) disable iff (rst)
    (state == S_LOAD) |=> (cmd[CMD_DIR_BIT] ? state == S_RX : state == S_WAIT))
    else $error("direction decode");
endmodule // swep_top

// file: rtl/swep_pkg.sv
// Package: constants shared by the single-wire memory access port.
// Assumes a 40 MHz system clock; all times are converted to cycles here.
package swep_pkg;

  // ****************************************************************
  // Clock and time figures
  // ****************************************************************
  localparam real CLK_MHZ       = 40.0;
  localparam real T_FILTER_US   = 1.98;     // Shortest low taken as a bit
  localparam real T_HOST_W1_US  = 50.0;     // Longest host one
  localparam real T_HOST_W0_US  = 86.0;     // Shortest host zero
  localparam real T_BREAK_US    = 190.0;    // Shortest break
  localparam real T_DEV_W1_US   = 41.0;
  localparam real T_DEV_W0_US   = 111.0;
  localparam real T_DEV_CYC_US  = 207.0;
  localparam real T_RSP_US      = 222.0;
  localparam real T_CRST_MS     = 4.0;
  localparam real F_SAMPLE_KHZ  = 65.5;
  localparam real T_CONV0_MS    = 125.0;
  localparam real T_CONV1_MS    = 62.5;
  localparam real T_CONV2_MS    = 31.25;
  localparam real T_CONV3_MS    = 7.8125;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam int FILT_CYC   = int'($ceil(T_FILTER_US * CLK_MHZ));
  localparam int THR_CYC    = int'($ceil((T_HOST_W1_US + T_HOST_W0_US) / 2.0 * CLK_MHZ));
  localparam int BREAK_CYC  = int'($ceil(T_BREAK_US * CLK_MHZ));
  localparam int DW1_CYC    = int'($ceil(T_DEV_W1_US * CLK_MHZ));
  localparam int DW0_CYC    = int'($ceil(T_DEV_W0_US * CLK_MHZ));
  localparam int DCYC_CYC   = int'($ceil(T_DEV_CYC_US * CLK_MHZ));
  localparam int RSP_CYC    = int'($ceil(T_RSP_US * CLK_MHZ));
  localparam int CRST_CYC   = int'($ceil(T_CRST_MS * 1000.0 * CLK_MHZ));
  localparam int SMP_CYC    = int'($ceil(CLK_MHZ * 1000.0 / F_SAMPLE_KHZ - 0.5));
  localparam int CONV0_CYC  = int'($ceil(T_CONV0_MS * 1000.0 * CLK_MHZ));
  localparam int CONV1_CYC  = int'($ceil(T_CONV1_MS * 1000.0 * CLK_MHZ));
  localparam int CONV2_CYC  = int'($ceil(T_CONV2_MS * 1000.0 * CLK_MHZ));
  localparam int CONV3_CYC  = int'($ceil(T_CONV3_MS * 1000.0 * CLK_MHZ));

  // ****************************************************************
  // Command byte and address layout
  // ****************************************************************
  localparam int CMD_DIR_BIT  = 7;      // 1 = host write
  localparam int CMD_MAP_BIT  = 6;      // 1 = memory space
  localparam int CMD_ROW_LSB  = 2;
  localparam int ROW_W        = 4;
  localparam int COL_W        = 2;
  localparam int PAGE_W       = 3;
  localparam int REG_W        = 6;
  localparam int WORDS        = 128;
  localparam int WORD_W       = 32;
  localparam int ADDR_W       = 7;
  localparam logic [PAGE_W-1:0] TRIM_PAGE    = 3'h7;
  localparam logic [ROW_W-1:0]  TRIM_ROW_MIN = 4'hC;  // Last 4 rows

  // Register space addresses
  localparam logic [REG_W-1:0] RA_BUF3   = 6'h03;
  localparam logic [REG_W-1:0] RA_STATUS = 6'h04;
  localparam logic [REG_W-1:0] RA_PAGE   = 6'h07;

  // ****************************************************************
  // Port state machine
  // ****************************************************************
  typedef enum logic [5:0] {
    S_RX    = 6'h01,
    S_FETCH = 6'h02,
    S_LOAD  = 6'h04,
    S_WAIT  = 6'h08,
    S_TX    = 6'h10,
    S_PROG  = 6'h20
  } swep_state_e;

endpackage

// file: rtl/swep_mem_if.sv
// Interface: word port between the serial engine and the array.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface swep_mem_if;
  import swep_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              rd_en;
  logic              wr_en;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] rdata;
  modport ctrl (output addr, output rd_en, output wr_en, output wdata, input rdata);
  modport mem  (input addr, input rd_en, input wr_en, input wdata, output rdata);
endinterface

// file: rtl/swep_mem.sv
// Word array with registered read data.
// Assumes one access per cycle; write and read never in the same cycle.
`timescale 1ns/1ps
module swep_mem
  import swep_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  swep_mem_if.mem   mif
);
  logic [WORD_W-1:0] array [WORDS];
  logic [WORD_W-1:0] next_rdata;
  logic [WORD_W-1:0] rdata_q;

  // Array content is not reset, like the real cells
  always_ff @(posedge clk) begin
    if (mif.wr_en) begin
      array[mif.addr] <= mif.wdata;
    end
  end

  // Read data held until the next read
  always_comb begin
    next_rdata = rdata_q;
    if (mif.rd_en) begin
      next_rdata = array[mif.addr];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= next_rdata;
    end
  end

  assign mif.rdata = rdata_q;
endmodule // swep_mem

// file: tb/swep_host.sv
// Host model: drives the shared wire low or releases it, and times device lows.
// Assumes the wire level is worked out outside from both pull enables and a pull-up.
`timescale 1ns/1ps
module swep_host (
  input  wire logic clk,
  input  wire logic line,
  output logic      pull
);
  initial pull = 1'b0;

  // ****************************************************************
  // Host bit timing
  // ****************************************************************
  // Lows and recovery scaled to the bench's shortened bit threshold of 300
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      pull <= 1'b1;
      repeat (b[i] ? 100 : 480) @(posedge clk);
      pull <= 1'b0;
      repeat (100) @(posedge clk);
    end
  endtask

  // Short low that the device must not take as a bit
  task automatic glitch(input int n);
    pull <= 1'b1;
    repeat (n) @(posedge clk);
    pull <= 1'b0;
    repeat (200) @(posedge clk);
  endtask

  // Device lows under 1700 read as one (ones 1640, bench zeros 1760), LSB first
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b1;
    b  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (line === 1'b1 && n < 12000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 12000) ok = 1'b0;
      n = 0;
      while (line === 1'b0 && n < 6000) begin
        @(posedge clk);
        n++;
      end
      b[i] = (n < 1700);
    end
  endtask
endmodule // swep_host

// file: tb/swep_top_tb.sv
// Testbench: host transactions, conversion timing and core reset hold.
// Assumes shortened bit threshold, device bit, reset and conversion counts on the port.
`timescale 1ns/1ps
module swep_top_tb;
  import swep_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sleep_req = 1'b0, shutdown_req = 1'b0;
  logic conv_start = 1'b0, err_clear = 1'b0, host_pull;
  logic [1:0] conv_speed = 2'h3;
  logic line_out, line_oe, core_reset, en_regulator, en_slow_oscillator, en_fast_oscillator;
  logic en_port, en_adc, en_mem_read, en_mem_write, adc_sample, conv_busy, adc_ready, prot_err;
  logic [PAGE_W-1:0] page;
  logic [7:0]        rb;
  logic              ok;
  wire               line_lvl;
  int                mismatches = 0, total_checks = 0, n;
  int                rd_cyc = 0, wr_cyc = 0, smp_cyc = 0;
  logic [7:0]        pwr;

  // Pull-up wins unless someone pulls low
  assign line_lvl = ~(line_oe | host_pull);
  always #12.5 clk = ~clk;

  // Power and port enables packed for one compare
  assign pwr = {3'h0, line_out, en_port, en_regulator, en_slow_oscillator, en_fast_oscillator};

  // Cycle counts of the array and modulator strobes
  always @(posedge clk) begin
    if (en_mem_read === 1'b1) rd_cyc <= rd_cyc + 1;
    if (en_mem_write === 1'b1) wr_cyc <= wr_cyc + 1;
    if (adc_sample === 1'b1) smp_cyc <= smp_cyc + 1;
  end

  swep_top #(.THR_C(300), .DW0_C(1760), .DCYC_C(1800), .CRST_C(50), .CONV3_C(200))
    dut_u (.clk(clk), .rst(rst), .line_in(line_lvl), .line_out(line_out),
    .line_oe(line_oe), .sleep_req(sleep_req), .shutdown_req(shutdown_req),
    .conv_start(conv_start), .conv_speed(conv_speed), .err_clear(err_clear),
    .core_reset(core_reset), .en_regulator(en_regulator),
    .en_slow_oscillator(en_slow_oscillator), .en_fast_oscillator(en_fast_oscillator),
    .en_port(en_port), .en_adc(en_adc), .en_mem_read(en_mem_read),
    .en_mem_write(en_mem_write), .adc_sample(adc_sample), .conv_busy(conv_busy),
    .adc_ready(adc_ready), .prot_err(prot_err), .page(page));

  swep_host host_u (.clk(clk), .line(line_lvl), .pull(host_pull));

  // ****************************************************************
  // Compare, access and closing tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    host_u.send_byte(cmd);
    host_u.send_byte(data);
    repeat (400) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    host_u.send_byte(cmd);
    host_u.recv_byte(rb, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t no answer to %s", $time, what);
      stop_test();
    end
    chk(rb, exp, what);
    repeat (400) @(posedge clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    @(posedge clk);
    while (core_reset === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, n >= 48 && n <= 51}, 8'h01, "core reset hold");
    chk(pwr, 8'h07, "idle enables");
    $display("test reset done");

    // Byte lane write through memory space, read back two ways
    host_u.glitch(40);
    wr(8'hCE, 8'hA5);
    rd(8'h02, 8'hA5, "buffer byte 2");
    rd(8'h4E, 8'hA5, "row 3 col 2");
    rd(8'h06, 8'h00, "spare register");
    $display("test memory access done");

    // Sleep, then wake by a break and keep the gap before data
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pwr, 8'h06, "sleep enables");
    host_u.glitch(7600);
    chk(pwr, 8'h07, "woken enables");
    repeat (7800) @(posedge clk);
    $display("test sleep done");

    // Trim words of the last page refuse writes
    wr(8'h87, 8'h07);
    chk({5'h00, page}, 8'h07, "page index");
    wr(8'hF0, 8'h5A);
    chk({7'h00, prot_err}, 8'h01, "trim write flagged");
    err_clear <= 1'b1;
    @(posedge clk);
    err_clear <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, prot_err}, 8'h00, "flag cleared");
    $display("test trim protect done");

    // Shutdown, then wake; no data break follows in this run
    shutdown_req <= 1'b1;
    @(posedge clk);
    shutdown_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pwr, 8'h00, "shutdown enables");
    host_u.glitch(7600);
    chk(pwr, 8'h07, "restart enables");
    chk(rd_cyc[7:0], 8'h06, "prefetch cycles");
    chk(wr_cyc[7:0], 8'h01, "program cycles");
    $display("test power modes done");

    // Fastest conversion speed
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    repeat (2) @(posedge clk);
    chk({6'h00, conv_busy, en_adc}, 8'h03, "converting");
    n = 2;
    while (adc_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, n >= 195 && n <= 205}, 8'h01, "conversion time");
    // Slower code must still be busy when the fastest would be done
    conv_speed <= 2'h2;
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    repeat (700) @(posedge clk);
    chk({7'h00, conv_busy}, 8'h01, "slow code busy");
    chk(smp_cyc[7:0], 8'h01, "modulator samples");
    $display("test conversion done");
    stop_test();
  end
endmodule // swep_top_tb
